// ==== bench/ims_slave.sv ====
// behavioural target device on the two-wire bus
// assumes pull-ups on both wires, resolved by the bench
module ims_slave
#(
	parameter logic [6:0] ADR = 7'h2a, // own address
	parameter logic [7:0] RDAT = 8'hc3 // byte sent on reads
)
(
	input wire logic scl, // clock wire
	input wire logic sda, // data wire
	output logic sda_n, // low pulls data low
	output logic nacked // master refused last byte
);
	logic [7:0] sh;
	logic go = 1'b0;
	logic hit;
	initial
	begin
		sda_n = 1'b1;
		nacked = 1'b0;
	end
	// a start aborts any frame under way
	always @(negedge sda iff scl)
	begin
		sda_n = 1'b1;
		go = 1'b1;
		disable body;
	end
	task automatic get;
		repeat (8) @(posedge scl) sh = {sh[6:0], sda};
	endtask
	task automatic ack(input logic n);
		@(negedge scl) sda_n = n;
		@(negedge scl) sda_n = 1'b1;
	endtask
	always
	begin : body
		wait (go);
		go = 1'b0;
		get();
		hit = sh[7:1] == ADR;
		ack(!hit);
		while (hit)
			if (sh[0])
			begin
				for (int i = 7; i >= 0; i--)
				begin
					sda_n = RDAT[i];
					@(negedge scl);
				end
				sda_n = 1'b1;
				@(posedge scl) nacked = sda;
				if (nacked)
					hit = 1'b0;
				else
					@(negedge scl);
			end
			else
			begin
				get();
				sh[0] = 1'b0;
				ack(1'b0);
			end
	end
endmodule

// ==== bench/ims_top_properties.sv ====
// checker for the two-wire sequencer, watching top-level ports only
// assumes ims_defs.svh on the include path
`include "ims_defs.svh"
module ims_chk
(
	input wire logic clock, // clock
	input wire logic rst, // reset
	input wire ims_pkg::ims_ahb_req_t ahb_req, // request
	input wire ims_pkg::ims_ahb_rsp_t ahb_rsp, // answer
	input wire ims_pkg::ims_pin_in_t pins_in, // wire levels
	input wire ims_pkg::ims_pin_out_t pins_out // enables
);
	import ims_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ==========================================
	// data-phase tracking and clock-low counter
	logic v, w, ok, held, act, wr, stp;
	logic [7:0] a;
	logic [10:0] lo;
	// a normal low phase never reaches this, so it marks a hold
	assign held = lo[10] & lo[9];
	assign wr = v & w & (a == `IMS_OFF_ADDR | a == `IMS_OFF_DATA
		| a == `IMS_OFF_SECOND_CONTROL_REGISTER & ahb_req.hwdata[17:16] != 2'h0);
	assign stp = v & w & a == `IMS_OFF_SECOND_CONTROL_REGISTER & ahb_req.hwdata[17:16] == 2'h3;
	assign act = wr | v & !w & a == `IMS_OFF_DATA;
	always_ff @(posedge clock or posedge rst)
		if (rst)
			{v, w, a, lo, ok} <= '0;
		else
		begin
			v <= ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
			w <= ahb_req.hwrite;
			a <= ahb_req.haddr[7:0];
			lo <= pins_out.scl_oe_n ? '0 : lo + (lo != '1);
			ok <= !pins_out.scl_oe_n & (ok | act);
		end
	// ==========================================
	// properties
	property p_rst; $fell(rst) |-> pins_out == 2'h3; endproperty
	property p_bus; ahb_rsp.hreadyout & !ahb_rsp.hresp; endproperty
	property p_rdz; !(v & !w) |-> ahb_rsp.hrdata == '0; endproperty
	property p_cmd; v & !w & a == `IMS_OFF_SECOND_CONTROL_REGISTER |-> ahb_rsp.hrdata[17:16] == 2'h0; endproperty
	property p_hold; held & !ok & !act |=> !pins_out.scl_oe_n; endproperty
	// a release, a stop or a (repeated) start lands within three quarters of a bit
	property p_rel; held & wr |-> ##[1:1000] pins_out.scl_oe_n; endproperty
	property p_stop;
		held & stp |-> ##[1:1000] ($rose(pins_out.sda_oe_n) & pins_out.scl_oe_n);
	endproperty
	property p_start;
		v & w & a == `IMS_OFF_ADDR |-> ##[1:1000] ($fell(pins_out.sda_oe_n) & pins_out.scl_oe_n);
	endproperty
	a_rst: assert property (p_rst) else $error("enables not idle after reset");
	a_bus: assert property (p_bus) else $error("bus answer not ready and okay");
	a_rdz: assert property (p_rdz) else $error("read data outside read phase");
	a_cmd: assert property (p_cmd) else $error("command bits read nonzero");
	a_hold: assert property (p_hold) else $error("held clock released");
	a_rel: assert property (p_rel) else $error("held clock not released");
	a_stop: assert property (p_stop) else $error("no stop after command");
	a_start: assert property (p_start) else $error("no start after address");
	c_rel: cover property (held & wr);
	c_stop: cover property (held & stp);
	c_read: cover property (held & act & !wr);
endmodule
bind ims_top ims_chk ims_chk_inst (.clock(clock), .rst(rst), .ahb_req(ahb_req),
	.ahb_rsp(ahb_rsp), .pins_in(pins_in), .pins_out(pins_out));

// ==== bench/ims_top_tb.sv ====
// self-checking bench for the two-wire sequencer
// assumes ims_slave as sole target, pull-ups on both wires
`include "ims_defs.svh"
module ims_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ims_pkg::*;
	localparam logic [7:0] TGT = 8'h54;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic jam_n = 1'b1;
	logic sda_n, nacked, scl, sda;
	logic [31:0] q;
	int error_cnt = 0;
	int tests_run = 0;
	ims_ahb_req_t req = '0;
	ims_ahb_req_t req_w;
	ims_ahb_rsp_t rsp;
	ims_pin_out_t po;
	always #4 clock = ~clock;
	assign req_w = {req[71:33], rsp.hreadyout, req[31:0]};
	assign scl = po.scl_oe_n;
	// jam_n stands in for a rival master
	assign sda = po.sda_oe_n & sda_n & jam_n;
	ims_top ims_top_inst (.clock(clock), .rst(rst), .ahb_req(req_w), .ahb_rsp(rsp),
		.pins_in({scl, sda}), .pins_out(po));
	ims_slave #(.ADR(TGT[7:1])) ims_slave_inst (.scl(scl), .sda(sda), .sda_n(sda_n),
		.nacked(nacked));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		req.haddr <= {24'h0, ad};
		req.hwrite <= wr;
		req.htrans <= 2'h2;
		req.hsize <= 3'h2;
		req.hsel <= 1'b1;
		do @(posedge clock); while (rsp.hreadyout !== 1'b1);
		req.htrans <= 2'h0;
		req.hwdata <= d;
		do @(posedge clock); while (rsp.hreadyout !== 1'b1);
		q = rsp.hrdata;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, ad, '0);
		chk(q & m, e);
	endtask
	task automatic poll(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
		int n;
		n = 0;
		do
		begin
			bus(1'b0, ad, '0);
			n++;
		end
		while ((q & m) !== e && n < 30000);
	endtask
	// long enough for the checker to tell a hold from a normal low phase
	task automatic hold_wait;
		repeat (1600) @(posedge clock);
	endtask
	task automatic t_reset;
		rd(`IMS_OFF_FLAG, '1, '0);
		rd(`IMS_OFF_STATUS, '1, '0);
		rd(`IMS_OFF_SECOND_CONTROL_REGISTER, '1, '0);
		bus(1'b1, 8'h08, '1);
		rd(8'h08, '1, '0);
	endtask
	task automatic t_write;
		bus(1'b1, `IMS_OFF_ADDR, {24'h0, TGT});
		poll(`IMS_OFF_FLAG, 32'h1, 32'h1);
		rd(`IMS_OFF_STATUS, 32'h86, 32'h80);
		bus(1'b1, `IMS_OFF_FLAG, '0);
		rd(`IMS_OFF_FLAG, 32'h3, 32'h1);
		hold_wait();
		bus(1'b1, `IMS_OFF_DATA, 32'h5a);
		rd(`IMS_OFF_FLAG, 32'h1, '0);
		poll(`IMS_OFF_FLAG, 32'h1, 32'h1);
		chk({24'h0, ims_slave_inst.sh}, 32'h5a);
		rd(`IMS_OFF_STATUS, 32'h86, 32'h80);
	endtask
	task automatic t_read;
		hold_wait();
		bus(1'b1, `IMS_OFF_ADDR, {24'h0, TGT | 8'h01});
		poll(`IMS_OFF_FLAG, 32'h2, 32'h2);
		rd(`IMS_OFF_FLAG, 32'h3, 32'h2);
		rd(`IMS_OFF_STATUS, 32'h84, 32'h80);
		bus(1'b1, `IMS_OFF_FLAG, 32'h2);
		rd(`IMS_OFF_FLAG, 32'h2, '0);
		rd(`IMS_OFF_STATUS, 32'h80, 32'h80);
		bus(1'b1, `IMS_OFF_SECOND_CONTROL_REGISTER, 32'h00040100);
		rd(`IMS_OFF_SECOND_CONTROL_REGISTER, 32'h00070100, 32'h00040100);
		hold_wait();
		rd(`IMS_OFF_DATA, 32'hff, 32'hc3);
		poll(`IMS_OFF_STATUS, 32'h80, '0);
		// the acknowledge bit and the stop that follows take eight quarters
		repeat (9 * `IMS_QUARTER_CYC) @(posedge clock);
		chk({31'h0, nacked}, 32'h1);
	endtask
	task automatic t_nack;
		bus(1'b1, `IMS_OFF_ADDR, 32'h22);
		poll(`IMS_OFF_FLAG, 32'h1, 32'h1);
		rd(`IMS_OFF_STATUS, 32'h84, 32'h84);
		hold_wait();
		bus(1'b1, `IMS_OFF_SECOND_CONTROL_REGISTER, 32'h00030000);
		poll(`IMS_OFF_STATUS, 32'h80, '0);
		rd(`IMS_OFF_FLAG, 32'h1, '0);
		// an address write during the stop would be ignored
		repeat (5 * `IMS_QUARTER_CYC) @(posedge clock);
	endtask
	task automatic t_clash;
		bus(1'b1, `IMS_OFF_ADDR, {24'h0, TGT});
		poll(`IMS_OFF_FLAG, 32'h1, 32'h1);
		rd(`IMS_OFF_STATUS, 32'h84, 32'h80);
		jam_n <= 1'b0;
		bus(1'b1, `IMS_OFF_DATA, 32'hff);
		poll(`IMS_OFF_FLAG, 32'h1, 32'h1);
		jam_n <= 1'b1;
		rd(`IMS_OFF_STATUS, 32'h82, 32'h02);
		rd(`IMS_OFF_FLAG, 32'h81, 32'h81);
	endtask
	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// seven bytes plus hold waits stay under 100k cycles
	initial
	begin
		#800000;
		error_cnt++;
		wrap_up();
	end
	initial
	begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_reset();
		t_write();
		t_read();
		t_nack();
		t_clash();
		wrap_up();
	end
endmodule

// ==== rtl/ims_defs.svh ====
// offsets, field positions and timing counts for the two-wire master sequencer
// assumes inclusion by name from rtl/ and bench/
`ifndef IMS_DEFS_SVH
`define IMS_DEFS_SVH
// ==========================================
// register byte offsets
`define IMS_OFF_SECOND_CONTROL_REGISTER 8'h04
`define IMS_OFF_FLAG 8'h18
`define IMS_OFF_STATUS 8'h1c
`define IMS_OFF_ADDR 8'h24
`define IMS_OFF_DATA 8'h28
// ==========================================
// field positions
`define IMS_B_SMART_MODE_ENABLE 8
`define IMS_B_ACKNOWLEDGE_ACTION_SELECT 18
`define IMS_CMD_LO 16
`define IMS_F_MB 0
`define IMS_F_SB 1
`define IMS_F_ERR 7
`define IMS_S_BUS_FAULT_STATUS 0
`define IMS_S_ARB 1
`define IMS_S_NACK 2
`define IMS_S_HOLD 7
`define IMS_S_MEXT 8
`define IMS_S_SEXT 9
`define IMS_S_LEN 10
`define IMS_S_LOWT 6
// ==========================================
// commands
`define IMS_CMD_NONE 2'h0
`define IMS_CMD_RSTART 2'h1
`define IMS_CMD_READ 2'h2
`define IMS_CMD_STOP 2'h3
// ==========================================
// timing: one quarter bit period, in clock cycles
`define IMS_QUARTER_NS 2500
`define IMS_CLK_NS 8
`define IMS_QUARTER_CYC ((`IMS_QUARTER_NS) / (`IMS_CLK_NS))
`define IMS_CNT_W 9
`endif

// ==== rtl/ims_pkg.sv ====
// types for the two-wire master sequencer
// assumes ims_defs.svh alongside
package ims_pkg;
	typedef struct packed
	{
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hsel;
		logic hready;
		logic [31:0] hwdata;
	} ims_ahb_req_t;
	typedef struct packed
	{
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} ims_ahb_rsp_t;
	typedef struct packed
	{
		logic scl_in;
		logic sda_in;
	} ims_pin_in_t;
	typedef struct packed
	{
		logic scl_oe_n;
		logic sda_oe_n;
	} ims_pin_out_t;
	typedef enum logic [8:0]
	{
		IMS_IDLE = 9'h001,
		IMS_START = 9'h002,
		IMS_BITS = 9'h004,
		IMS_ACKB = 9'h008,
		IMS_HOLD = 9'h010,
		IMS_STOP = 9'h020,
		IMS_RSTRT = 9'h040,
		IMS_RACK = 9'h080,
		IMS_LOST = 9'h100
	} ims_state_t;
endpackage

// ==== rtl/ims_top.sv ====
// two-wire master packet sequencer with an AHB-Lite register slave
// assumes open-drain wires resolved outside; scl_oe_n low pulls the line low
`include "ims_defs.svh"
// ==========================================
// sequencer
module ims_top
(
	input wire logic clock, // 125 MHz
	input wire logic rst, // async, active high
	input wire ims_pkg::ims_ahb_req_t ahb_req, // bus request
	output ims_pkg::ims_ahb_rsp_t ahb_rsp, // bus answer
	input wire ims_pkg::ims_pin_in_t pins_in, // wire levels
	output ims_pkg::ims_pin_out_t pins_out // open-drain enables
);
	import ims_pkg::*;
	typedef struct packed
	{
		ims_state_t st;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic scl_f;
		logic sda_f;
		logic [`IMS_CNT_W-1:0] cnt;
		logic [1:0] ph;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic rd;
		logic owner;
		logic sda_o;
		logic scl_o;
		logic addr_pkt;
		logic pend_addr;
		logic smart_mode_enable;
		logic acknowledge_action_select;
		logic [7:0] addr;
		logic [7:0] data;
		logic mb;
		logic sb;
		logic err;
		logic arb;
		logic nack;
		logic bus_fault_status;
		logic dph;
		logic dwr;
		logic [7:0] da;
		logic [31:0] rdata;
	} ims_s_t;
	ims_s_t s, n;
	// ==========================================
	// bus decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction
	logic wr_ctl, wr_flag, wr_addr, wr_data, rd_data;
	logic [31:0] wd;
	logic held;
	logic [1:0] cmd;
	logic quarter;
	always_comb
	begin
		wd = ahb_req.hwdata;
		wr_ctl = s.dph && s.dwr && hit(s.da, `IMS_OFF_SECOND_CONTROL_REGISTER);
		wr_flag = s.dph && s.dwr && hit(s.da, `IMS_OFF_FLAG);
		wr_addr = s.dph && s.dwr && hit(s.da, `IMS_OFF_ADDR);
		wr_data = s.dph && s.dwr && hit(s.da, `IMS_OFF_DATA);
		rd_data = s.dph && !s.dwr && hit(s.da, `IMS_OFF_DATA);
		cmd = wd[`IMS_CMD_LO+1:`IMS_CMD_LO];
		held = (s.st == IMS_HOLD);
		quarter = (s.cnt == `IMS_CNT_W'(`IMS_QUARTER_CYC - 1));
	end
	always_comb
	begin
		n = s;
		// three-stage sampling; a change counts when stages two and three agree
		n.scl_s = {s.scl_s[1:0], pins_in.scl_in};
		n.sda_s = {s.sda_s[1:0], pins_in.sda_in};
		if (s.scl_s[2] == s.scl_s[1])
			n.scl_f = s.scl_s[2];
		if (s.sda_s[2] == s.sda_s[1])
			n.sda_f = s.sda_s[2];
		// ahb-lite slave: zero wait states, always OKAY
		n.dph = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
		n.dwr = ahb_req.hwrite;
		n.da = ahb_req.haddr[7:0];
		n.rdata = 32'h0;
		if (n.dph && !ahb_req.hwrite)
		begin
			case (ahb_req.haddr[7:0])
				`IMS_OFF_SECOND_CONTROL_REGISTER: n.rdata = ({31'h0, s.smart_mode_enable} << `IMS_B_SMART_MODE_ENABLE)
					| ({31'h0, s.acknowledge_action_select} << `IMS_B_ACKNOWLEDGE_ACTION_SELECT);
				`IMS_OFF_FLAG: n.rdata = ({31'h0, s.mb} << `IMS_F_MB)
					| ({31'h0, s.sb} << `IMS_F_SB) | ({31'h0, s.err} << `IMS_F_ERR);
				`IMS_OFF_STATUS: n.rdata = ({31'h0, s.bus_fault_status} << `IMS_S_BUS_FAULT_STATUS)
					| ({31'h0, s.arb} << `IMS_S_ARB) | ({31'h0, s.nack} << `IMS_S_NACK)
					| ({31'h0, held} << `IMS_S_HOLD);
				`IMS_OFF_ADDR: n.rdata = {24'h0, s.addr};
				`IMS_OFF_DATA: n.rdata = {24'h0, s.data};
				default: n.rdata = 32'h0;
			endcase
		end
		if (wr_ctl)
		begin
			n.smart_mode_enable = wd[`IMS_B_SMART_MODE_ENABLE];
			n.acknowledge_action_select = wd[`IMS_B_ACKNOWLEDGE_ACTION_SELECT];
		end
		// write-one clears; hardware sets below win over these
		if (wr_flag && wd[`IMS_F_SB])
			n.sb = 1'b0;
		if (wr_flag && wd[`IMS_F_MB])
			n.mb = 1'b0;
		if (wr_flag && wd[`IMS_F_ERR])
			n.err = 1'b0;
		if (wr_addr)
			n.addr = wd[7:0];
		if (wr_data)
			n.data = wd[7:0];
		n.cnt = quarter ? `IMS_CNT_W'(0) : s.cnt + `IMS_CNT_W'(1);
		case (s.st)
			IMS_IDLE:
			begin
				n.scl_o = 1'b1;
				n.sda_o = 1'b1;
				if (wr_addr)
				begin
					n.sh = wd[7:0];
					n.rd = wd[0];
					n.addr_pkt = 1'b1;
					n.arb = 1'b0;
					n.bus_fault_status = 1'b0;
					n.st = IMS_START;
					n.ph = 2'h0;
					n.cnt = `IMS_CNT_W'(0);
				end
			end
			IMS_START:
				if (quarter)
				begin
					n.ph = s.ph + 2'h1;
					if (s.ph == 2'h0)
						n.sda_o = 1'b0;
					if (s.ph == 2'h1)
					begin
						n.scl_o = 1'b0;
						n.owner = 1'b1;
						n.bitn = 4'h0;
						n.ph = 2'h0;
						n.st = IMS_BITS;
					end
				end
			IMS_BITS:
				if (quarter)
				begin
					n.ph = s.ph + 2'h1;
					case (s.ph)
						2'h0: n.sda_o = (s.addr_pkt || !s.rd) ? s.sh[7] : 1'b1;
						2'h1: n.scl_o = 1'b1;
						2'h2:
						begin
							n.sh = {s.sh[6:0], s.sda_f};
							// collision: drove high but the line reads low
							if ((s.addr_pkt || !s.rd) && s.sda_o && !s.sda_f)
							begin
								n.arb = 1'b1;
								n.owner = 1'b0;
								n.mb = 1'b1;
								n.st = IMS_LOST;
							end
						end
						default:
						begin
							n.scl_o = 1'b0;
							n.bitn = s.bitn + 4'h1;
							if (s.bitn == 4'h7)
							begin
								if (s.addr_pkt || !s.rd)
									n.st = IMS_ACKB;
								else
								begin
									n.data = s.sh;
									n.sb = 1'b1;
									n.nack = 1'b0;
									n.st = IMS_HOLD;
								end
							end
						end
					endcase
				end
			IMS_ACKB:
				if (quarter)
				begin
					n.ph = s.ph + 2'h1;
					case (s.ph)
						2'h0: n.sda_o = 1'b1;
						2'h1: n.scl_o = 1'b1;
						2'h2: n.nack = s.sda_f;
						default:
						begin
							n.scl_o = 1'b0;
							if (s.addr_pkt && s.rd && !s.nack)
							begin
								n.addr_pkt = 1'b0;
								n.bitn = 4'h0;
								n.st = IMS_BITS;
							end
							else
							begin
								n.mb = 1'b1;
								n.st = IMS_HOLD;
							end
						end
					endcase
				end
			IMS_RACK:
				if (quarter)
				begin
					n.ph = s.ph + 2'h1;
					case (s.ph)
						2'h0: n.sda_o = s.acknowledge_action_select;
						2'h1: n.scl_o = 1'b1;
						2'h2:
							if (s.sda_o && !s.sda_f)
							begin
								n.arb = 1'b1;
								n.owner = 1'b0;
								n.mb = 1'b1;
								n.st = IMS_LOST;
							end
						default:
						begin
							n.scl_o = 1'b0;
							n.bitn = 4'h0;
							n.st = s.acknowledge_action_select ? IMS_STOP : IMS_BITS;
						end
					endcase
				end
			IMS_HOLD:
			begin
				n.scl_o = 1'b0;
				n.ph = 2'h0;
				n.cnt = `IMS_CNT_W'(0);
				if (wr_addr)
				begin
					n.mb = 1'b0;
					n.sb = 1'b0;
					n.sh = wd[7:0];
					n.rd = wd[0];
					n.addr_pkt = 1'b1;
					n.st = IMS_RSTRT;
				end
				else if (wr_data && !s.rd)
				begin
					n.mb = 1'b0;
					n.sb = 1'b0;
					n.sh = wd[7:0];
					n.addr_pkt = 1'b0;
					n.bitn = 4'h0;
					n.st = IMS_BITS;
				end
				else if ((rd_data && s.smart_mode_enable && s.rd) || (wr_ctl && cmd == `IMS_CMD_READ))
				begin
					n.mb = 1'b0;
					n.sb = 1'b0;
					n.st = IMS_RACK;
				end
				else if (wr_ctl && cmd == `IMS_CMD_STOP)
				begin
					n.mb = 1'b0;
					n.sb = 1'b0;
					n.st = IMS_STOP;
				end
				else if (wr_ctl && cmd == `IMS_CMD_RSTART)
				begin
					n.mb = 1'b0;
					n.sb = 1'b0;
					n.sh = s.addr;
					n.rd = s.addr[0];
					n.addr_pkt = 1'b1;
					n.st = IMS_RSTRT;
				end
			end
			IMS_RSTRT:
				if (quarter)
				begin
					n.ph = s.ph + 2'h1;
					if (s.ph == 2'h0)
						n.sda_o = 1'b1;
					if (s.ph == 2'h1)
					begin
						n.scl_o = 1'b1;
						n.ph = 2'h0;
						n.st = IMS_START;
					end
				end
			IMS_STOP:
				if (quarter)
				begin
					n.ph = s.ph + 2'h1;
					case (s.ph)
						2'h0: n.sda_o = 1'b0;
						2'h1: n.scl_o = 1'b1;
						2'h2: n.sda_o = 1'b1;
						default:
						begin
							n.owner = 1'b0;
							n.st = IMS_IDLE;
						end
					endcase
				end
			IMS_LOST:
			begin
				// released wires; no hold after a lost arbitration
				n.scl_o = 1'b1;
				n.sda_o = 1'b1;
				n.st = IMS_IDLE;
			end
			default: n.st = IMS_IDLE;
		endcase
		if (n.arb || n.bus_fault_status)
			n.err = 1'b1;
	end
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s <= '0;
			s.st <= IMS_IDLE;
			s.scl_s <= 3'h7;
			s.sda_s <= 3'h7;
			s.scl_f <= 1'b1;
			s.sda_f <= 1'b1;
			s.scl_o <= 1'b1;
			s.sda_o <= 1'b1;
		end
		else
			s <= n;
	end
	// ==========================================
	// outputs from flip-flops, with hreadyout and hresp tied off
	assign ahb_rsp.hrdata = s.rdata;
	assign ahb_rsp.hreadyout = 1'b1;
	assign ahb_rsp.hresp = 1'b0;
	assign pins_out.scl_oe_n = s.scl_o;
	assign pins_out.sda_oe_n = s.sda_o;
endmodule
